// File: logic/pmt_mem_if.sv
`timescale 1ns/100ps
// ==========================================================
// port between the sequencer and the program store
interface pmt_mem_if #(
  parameter int unsigned AW = 12,
  parameter int unsigned DW = 16
);
  logic [AW-1:0] rd_addr;  // read address, sampled every edge
  logic [DW-1:0] rd_data;  // registered read word
  logic          wr_en;    // programming write strobe
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;

  modport ctrl  (output rd_addr, output wr_en, output wr_addr, output wr_data,
                 input rd_data);
  modport store (input rd_addr, input wr_en, input wr_addr, input wr_data,
                 output rd_data);
endinterface

// File: logic/pmt_pkg.sv
package pmt_pkg;
  // ==========================================================
  // program store shape
  localparam int unsigned DEPTH_WORDS  = 4096;  // smaller variant, up to 8192
  localparam int unsigned WORD_BITS    = 16;    // program word width
  localparam int unsigned BYTE_BITS    = 8;
  localparam int unsigned PAGE_BITS    = 8;     // one page is 256 words
  localparam logic [15:0] RESET_VECTOR = 16'h0000;

  // ==========================================================
  // data memory destination of a table read
  localparam int unsigned DM_SECT_BITS = 2;     // sector number
  localparam int unsigned DM_OFF_BITS  = 8;     // offset inside a sector
  localparam int unsigned DM_ADDR_BITS = 10;    // sector and offset
  localparam logic [1:0]  SECTOR_ZERO  = 2'h0;

  // ==========================================================
  // table read kind: bit 0 last page, bit 1 far form
  localparam int unsigned KIND_LAST_POS = 0;
  localparam int unsigned KIND_FAR_POS  = 1;
  localparam logic [1:0] near_table_read_current_page = 2'h0;
  localparam logic [1:0] near_table_read_last_page    = 2'h1;
  localparam logic [1:0] far_table_read_current_page  = 2'h2;
  localparam logic [1:0] far_table_read_last_page     = 2'h3;

  // ==========================================================
  // reset values of the table registers
  localparam logic [7:0] TBLP_RST = 8'h00;
  localparam logic [7:0] PTR_HIGH_RST = 8'h00;
  localparam logic [7:0] LATCH_RST    = 8'h00;

  // ==========================================================
  // programming frame: 32 bits, first bit is bit 31
  localparam int unsigned FRAME_BITS   = 32;
  localparam int unsigned FR_WRITE_POS = 31;    // 1 write, 0 read
  localparam int unsigned FR_EE_POS    = 30;    // 1 eeprom, 0 program store
  localparam int unsigned FR_ADDR_POS  = 16;
  localparam int unsigned FR_ADDR_BITS = 14;
  localparam int unsigned FR_DATA_POS  = 0;
  localparam logic [4:0]  REPLY_START  = 5'h03; // frame bit where a reply loads
  localparam logic [4:0]  REPLY_BITS   = 5'h10; // reply length in bits
  localparam logic [4:0]  FRAME_LAST   = 5'h1f;

  // ==========================================================
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_FETCH = 4'h1,
    ST_TAB   = 4'h2,
    ST_XFER  = 4'h4,
    ST_PROG  = 4'h8
  } pmt_state_t;
endpackage

// File: logic/pmt_prog_store.sv
`timescale 1ns/100ps
// ==========================================================
// program store: one registered read port, one write port
module pmt_prog_store #(
  parameter int unsigned DEPTH = 4096,
  parameter int unsigned AW    = 12,
  parameter int unsigned DW    = 16
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // access port
  pmt_mem_if.store mp
);
  logic [DW-1:0] cells [DEPTH];  // array itself carries no reset

  // ==========================================================
  // write side, no reset so it maps onto a plain ram
  always_ff @(posedge i_clk) begin
    if (mp.wr_en) begin
      cells[mp.wr_addr] <= mp.wr_data;
    end
  end

  // ==========================================================
  // read register, reset so the fetched word is defined early
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mp.rd_data <= '0;
    end else begin
      mp.rd_data <= cells[mp.rd_addr];
    end
  end
endmodule

// File: logic/pmt_program_memory_table_read.sv
`timescale 1ns/100ps
module pmt_program_memory_table_read #(
  parameter int unsigned DEPTH = pmt_pkg::DEPTH_WORDS,
  parameter int unsigned PW    = pmt_pkg::WORD_BITS,  // backed bits per word
  parameter int unsigned AW    = $clog2(DEPTH)
) (
  // clocks and reset
  input  wire logic                               i_clk,
  input  wire logic                               i_rst_b,
  input  wire logic                               i_prog_serial_clock,
  // table read request from the core
  input  wire logic                               i_tab_req,
  input  wire logic [1:0]                         i_tab_kind,
  input  wire logic [pmt_pkg::DM_ADDR_BITS-1:0]   i_tab_dest,
  // table register writes from the core
  input  wire logic [7:0]                         i_ptr_wdata,
  input  wire logic                               i_tblp_wr,
  input  wire logic                               i_ptr_high_wr,
  input  wire logic                               i_latch_wr,
  output logic [7:0]                              o_table_pointer_low,
  output logic [AW-pmt_pkg::PAGE_BITS-1:0]        o_table_pointer_high,
  output logic [7:0]                              o_table_high_byte_latch,
  // data memory write of the low table byte
  output logic                                    o_dm_wr,
  output logic [pmt_pkg::DM_ADDR_BITS-1:0]        o_dm_addr,
  output logic [7:0]                              o_dm_data,
  // instruction fetch
  output logic [AW-1:0]                           o_fetch_addr,
  output logic [pmt_pkg::WORD_BITS-1:0]           o_instr,
  output logic                                    o_instr_valid,
  output logic                                    o_busy,
  // eeprom data store
  output logic                                    o_ee_wr,
  output logic [pmt_pkg::FR_ADDR_BITS-1:0]        o_ee_addr,
  output logic [7:0]                              o_ee_wdata,
  input  wire logic [7:0]                         i_ee_rdata,
  // programming data line
  input  wire logic                               i_prog_serial_data,
  output logic                                    o_prog_serial_data,
  output logic                                    o_prog_serial_data_oe
);
  localparam logic [AW-1:0] LAST_BASE = AW'(DEPTH - 2**pmt_pkg::PAGE_BITS);
  localparam logic [7:0]    HI_MASK   = 8'((2**(PW-pmt_pkg::BYTE_BITS)) - 1);
  localparam int unsigned   HW        = AW - pmt_pkg::PAGE_BITS;

  pmt_mem_if #(.AW(AW), .DW(pmt_pkg::WORD_BITS)) mem ();

  pmt_prog_store #(.DEPTH(DEPTH), .AW(AW), .DW(pmt_pkg::WORD_BITS)) u_store (
    .i_clk   (i_clk),
    .i_rst_b (i_rst_b),
    .mp      (mem.store)
  );

  // destination: near forms are confined to sector zero
  function automatic logic [pmt_pkg::DM_ADDR_BITS-1:0] dest_of(
    input logic [1:0] kind, input logic [pmt_pkg::DM_ADDR_BITS-1:0] dest);
    dest_of = dest;
    if (!kind[pmt_pkg::KIND_FAR_POS]) begin
      dest_of[pmt_pkg::DM_ADDR_BITS-1 -: pmt_pkg::DM_SECT_BITS] = pmt_pkg::SECTOR_ZERO;
    end
  endfunction

  // ==========================================================
  // core domain state
  pmt_pkg::pmt_state_t                   st, next_st;        // sequencer
  logic [AW-1:0]                         pc, next_pc;        // program counter
  logic [7:0]                            tblp, next_tblp;    // pointer low
  logic [HW-1:0]                         ptr_high, next_ptr_high; // pointer high
  logic [7:0]                            hi_latch, next_hi_latch; // high byte latch
  logic                                  busy, next_busy;    // flop behind o_busy
  logic [1:0]                            kind, next_kind;    // held table form
  logic [pmt_pkg::DM_ADDR_BITS-1:0]      dest, next_dest;    // held destination
  logic                                  dm_wr, next_dm_wr;
  logic [pmt_pkg::DM_ADDR_BITS-1:0]      dm_addr, next_dm_addr;
  logic [7:0]                            dm_data, next_dm_data;
  logic [AW-1:0]                         faddr, next_faddr;  // address of o_instr
  logic                                  ivalid, next_ivalid;
  logic                                  ee_wr, next_ee_wr;
  logic [pmt_pkg::FR_ADDR_BITS-1:0]      ee_addr, next_ee_addr;
  logic [7:0]                            ee_wdata, next_ee_wdata;
  logic                                  cs1, cs2, cack, next_cack; // word sync
  logic                                  pend, next_pend;    // command waiting
  logic                                  pcap, next_pcap;    // capture read word
  logic [15:0]                           rhold, next_rhold;  // reply word
  logic                                  rtog, next_rtog;    // reply toggle
  logic [AW-1:0]                         tab_addr;
  logic [pmt_pkg::FRAME_BITS-1:0]        lk_word;            // link-held command
  logic                                  lk_tog;

  wire logic cmd_wr = lk_word[pmt_pkg::FR_WRITE_POS];
  wire logic cmd_ee = lk_word[pmt_pkg::FR_EE_POS];
  wire logic [pmt_pkg::FR_ADDR_BITS-1:0] cmd_addr =
    lk_word[pmt_pkg::FR_ADDR_POS +: pmt_pkg::FR_ADDR_BITS];
  wire logic [15:0] cmd_data = lk_word[pmt_pkg::FR_DATA_POS +: 16];

  // ==========================================================
  // table address: full pointer, or offset into the last page
  always_comb begin
    if (kind[pmt_pkg::KIND_LAST_POS]) begin
      tab_addr = LAST_BASE | {{HW{1'b0}}, tblp};
    end else begin
      tab_addr = {ptr_high, tblp};
    end
  end

  // ==========================================================
  // sequencer next values
  always_comb begin
    next_st       = st;
    next_pc       = pc;
    next_tblp     = i_tblp_wr ? i_ptr_wdata : tblp;
    next_ptr_high = i_ptr_high_wr ? i_ptr_wdata[HW-1:0] : ptr_high;
    next_hi_latch = i_latch_wr ? i_ptr_wdata : hi_latch;
    next_kind     = kind;
    next_dest     = dest;
    next_dm_wr    = 1'b0;
    next_dm_addr  = dm_addr;
    next_dm_data  = dm_data;
    next_faddr    = faddr;
    next_ivalid   = 1'b0;
    next_ee_wr    = 1'b0;
    next_ee_addr  = ee_addr;
    next_ee_wdata = ee_wdata;
    next_cack     = cs2;
    next_pend     = pend | (cs2 != cack);  // a new word is never lost
    next_pcap     = 1'b0;
    next_rhold    = rhold;
    next_rtog     = rtog;
    mem.rd_addr   = pc;
    mem.wr_en     = 1'b0;
    mem.wr_addr   = cmd_addr[AW-1:0];
    mem.wr_data   = cmd_data;
    // program store read word from the previous programming cycle
    if (pcap) begin
      next_rhold = mem.rd_data;
      next_rtog  = ~rtog;
    end
    case (st)
      pmt_pkg::ST_FETCH: begin
        next_pc     = pc + 1'b1;
        next_faddr  = pc;
        next_ivalid = 1'b1;
        if (i_tab_req) begin
          next_kind = i_tab_kind;
          next_dest = i_tab_dest;
          next_st   = pmt_pkg::ST_TAB;
        end else if (pend) begin
          next_st = pmt_pkg::ST_PROG;
        end
      end
      pmt_pkg::ST_TAB: begin
        // port serves the table word, counter stands still
        mem.rd_addr = tab_addr;
        next_st     = pmt_pkg::ST_XFER;
      end
      pmt_pkg::ST_XFER: begin
        // fetch resumes while the table word is handed out
        next_pc      = pc + 1'b1;
        next_faddr   = pc;
        next_ivalid  = 1'b1;
        next_dm_wr   = 1'b1;
        next_dm_addr = dest_of(kind, dest);
        next_dm_data = mem.rd_data[7:0];
        next_hi_latch = mem.rd_data[15:8] & HI_MASK;
        next_st      = pmt_pkg::ST_FETCH;
      end
      pmt_pkg::ST_PROG: begin
        // one command from the programmer; counter holds
        next_pend = cs2 != cack;
        if (cmd_wr && !cmd_ee) begin
          mem.wr_en = 1'b1;
        end else if (cmd_wr) begin
          next_ee_wr    = 1'b1;
          next_ee_addr  = cmd_addr;
          next_ee_wdata = cmd_data[7:0];
        end else if (!cmd_ee) begin
          mem.rd_addr = cmd_addr[AW-1:0];
          next_pcap   = 1'b1;
        end else begin
          next_rhold = {8'h00, i_ee_rdata};
          next_rtog  = ~rtog;
        end
        next_st = pmt_pkg::ST_FETCH;
      end
      default: begin
        next_st = pmt_pkg::ST_FETCH;
      end
    endcase
    // busy follows the next state so the output comes from a flop
    next_busy = (next_st != pmt_pkg::ST_FETCH);
  end

  // ==========================================================
  // sequencer registers
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st       <= pmt_pkg::ST_FETCH;
      pc       <= pmt_pkg::RESET_VECTOR[AW-1:0];
      tblp     <= pmt_pkg::TBLP_RST;
      ptr_high <= pmt_pkg::PTR_HIGH_RST[HW-1:0];
      hi_latch <= pmt_pkg::LATCH_RST;
      busy     <= 1'b0;
      kind     <= pmt_pkg::near_table_read_current_page;
      dest     <= '0;
      dm_wr    <= 1'b0;
      dm_addr  <= '0;
      dm_data  <= '0;
      faddr    <= '0;
      ivalid   <= 1'b0;
      ee_wr    <= 1'b0;
      ee_addr  <= '0;
      ee_wdata <= '0;
      cs1      <= 1'b0;
      cs2      <= 1'b0;
      cack     <= 1'b0;
      pend     <= 1'b0;
      pcap     <= 1'b0;
      rhold    <= '0;
      rtog     <= 1'b0;
    end else begin
      st       <= next_st;
      pc       <= next_pc;
      tblp     <= next_tblp;
      ptr_high <= next_ptr_high;
      hi_latch <= next_hi_latch;
      busy     <= next_busy;
      kind     <= next_kind;
      dest     <= next_dest;
      dm_wr    <= next_dm_wr;
      dm_addr  <= next_dm_addr;
      dm_data  <= next_dm_data;
      faddr    <= next_faddr;
      ivalid   <= next_ivalid;
      ee_wr    <= next_ee_wr;
      ee_addr  <= next_ee_addr;
      ee_wdata <= next_ee_wdata;
      cs1      <= lk_tog;  // first stage, read only by cs2
      cs2      <= cs1;
      cack     <= next_cack;
      pend     <= next_pend;
      pcap     <= next_pcap;
      rhold    <= next_rhold;
      rtog     <= next_rtog;
    end
  end

  // ==========================================================
  // link domain, clocked by the programmer only during frames
  logic [4:0]                     lk_cnt, next_lk_cnt;     // bit in frame
  logic [pmt_pkg::FRAME_BITS-1:0] lk_shift, next_lk_shift;
  logic [pmt_pkg::FRAME_BITS-1:0] next_lk_word;
  logic                           next_lk_tog;
  logic                           lr1, lr2, lk_rack, next_lk_rack; // reply sync
  logic [15:0]                    lk_out, next_lk_out;
  logic                           lk_oe, next_lk_oe;
  logic                           lk_dout, next_lk_dout;
  logic                           lk_rframe, next_lk_rframe;     // reply frame

  always_comb begin
    next_lk_shift  = {lk_shift[pmt_pkg::FRAME_BITS-2:0], i_prog_serial_data};
    next_lk_cnt    = lk_cnt + 1'b1;  // wraps at the frame end
    next_lk_word   = lk_word;
    next_lk_tog    = lk_tog;
    next_lk_rack   = lk_rack;
    next_lk_out    = lk_out;
    next_lk_oe     = lk_oe;
    next_lk_dout   = lk_dout;
    next_lk_rframe = lk_rframe;
    // a pending reply takes over the data line for sixteen bits
    if (lk_cnt == pmt_pkg::REPLY_START && lr2 != lk_rack) begin
      next_lk_rack   = lr2;
      next_lk_oe     = 1'b1;
      next_lk_dout   = rhold[15];
      next_lk_out    = {rhold[14:0], 1'b0};
      next_lk_rframe = 1'b1;
    end else if (lk_oe) begin
      if (lk_cnt == pmt_pkg::REPLY_START + pmt_pkg::REPLY_BITS) begin
        next_lk_oe = 1'b0;
      end else begin
        next_lk_dout = lk_out[15];
        next_lk_out  = {lk_out[14:0], 1'b0};
      end
    end
    // frame end: a command frame is handed to the core
    if (lk_cnt == pmt_pkg::FRAME_LAST) begin
      next_lk_rframe = 1'b0;
      if (!lk_rframe) begin
        next_lk_word = next_lk_shift;
        next_lk_tog  = ~lk_tog;
      end
    end
  end

  always_ff @(posedge i_prog_serial_clock or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lk_cnt    <= '0;
      lk_shift  <= '0;
      lk_word   <= '0;
      lk_tog    <= 1'b0;
      lr1       <= 1'b0;
      lr2       <= 1'b0;
      lk_rack   <= 1'b0;
      lk_out    <= '0;
      lk_oe     <= 1'b0;
      lk_dout   <= 1'b0;
      lk_rframe <= 1'b0;
    end else begin
      lk_cnt    <= next_lk_cnt;
      lk_shift  <= next_lk_shift;
      lk_word   <= next_lk_word;
      lk_tog    <= next_lk_tog;
      lr1       <= rtog;  // first stage, read only by lr2
      lr2       <= lr1;
      lk_rack   <= next_lk_rack;
      lk_out    <= next_lk_out;
      lk_oe     <= next_lk_oe;
      lk_dout   <= next_lk_dout;
      lk_rframe <= next_lk_rframe;
    end
  end

  // ==========================================================
  // outputs, all from flip-flops
  assign o_table_pointer_low     = tblp;
  assign o_table_pointer_high    = ptr_high;
  assign o_table_high_byte_latch = hi_latch;
  assign o_dm_wr                 = dm_wr;
  assign o_dm_addr               = dm_addr;
  assign o_dm_data               = dm_data;
  assign o_fetch_addr            = faddr;
  assign o_instr                 = mem.rd_data;
  assign o_instr_valid           = ivalid;
  assign o_busy                  = busy;
  assign o_ee_wr                 = ee_wr;
  assign o_ee_addr               = ee_addr;
  assign o_ee_wdata              = ee_wdata;
  assign o_prog_serial_data      = lk_dout;
  assign o_prog_serial_data_oe   = lk_oe;

  // ==========================================================
  // checks
  logic first_fetch;  // set until the first fetch after reset
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      first_fetch <= 1'b1;
    end else begin
      first_fetch <= 1'b0;
    end
  end

  sequence seq_tab_issue;
    st == pmt_pkg::ST_TAB && mem.rd_addr == tab_addr;
  endsequence
  sequence seq_tab_xfer;
    st == pmt_pkg::ST_XFER ##1 (o_dm_wr && st == pmt_pkg::ST_FETCH);
  endsequence

  chk_reset_vector: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    first_fetch |-> (mem.rd_addr == '0 && st == pmt_pkg::ST_FETCH))
    else $error("first fetch after reset is not at address zero");
  chk_tab_two_cycles: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st == pmt_pkg::ST_FETCH && i_tab_req) |=> seq_tab_issue ##1 seq_tab_xfer)
    else $error("table read did not finish in two cycles");
  chk_pc_held: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == pmt_pkg::ST_TAB |=> (pc == $past(pc) && !o_instr_valid))
    else $error("counter moved during table cycle");
  chk_fetch_advance: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == pmt_pkg::ST_FETCH |=> (pc == $past(pc) + 1'b1 && o_fetch_addr == $past(pc)))
    else $error("fetch did not advance the counter");
  chk_tab_full_addr: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st == pmt_pkg::ST_TAB && !kind[pmt_pkg::KIND_LAST_POS])
      |-> mem.rd_addr == {ptr_high, tblp})
    else $error("table address is not the pointer pair");
  chk_last_page: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st == pmt_pkg::ST_TAB && kind[pmt_pkg::KIND_LAST_POS])
      |-> mem.rd_addr == (LAST_BASE | {{HW{1'b0}}, tblp}))
    else $error("last page table address wrong");
  chk_low_byte: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == pmt_pkg::ST_XFER |=> (o_dm_wr && o_dm_data == $past(mem.rd_data[7:0])))
    else $error("low table byte not written to data memory");
  chk_high_byte: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    st == pmt_pkg::ST_XFER |=> hi_latch == ($past(mem.rd_data[15:8]) & HI_MASK))
    else $error("high table byte not latched");
  chk_unused_zero: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    $rose(o_dm_wr) |-> (hi_latch & ~HI_MASK) == 8'h00)
    else $error("unbacked latch bit is not zero");
  chk_near_sector: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st == pmt_pkg::ST_XFER && !kind[pmt_pkg::KIND_FAR_POS])
      |=> o_dm_addr[pmt_pkg::DM_ADDR_BITS-1 -: 2] == pmt_pkg::SECTOR_ZERO)
    else $error("near form wrote outside sector zero");
  chk_far_sector: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st == pmt_pkg::ST_XFER && kind[pmt_pkg::KIND_FAR_POS]) |=> o_dm_addr == $past(dest))
    else $error("far form destination wrong");
  chk_latch_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (i_latch_wr && st != pmt_pkg::ST_XFER) |=> hi_latch == $past(i_ptr_wdata))
    else $error("software write to latch lost");
  chk_prog_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
    (st == pmt_pkg::ST_PROG && cmd_wr) |-> (cmd_ee ? next_ee_wr : mem.wr_en))
    else $error("programming write not issued");
  chk_reply_len: assert property (@(posedge i_prog_serial_clock) disable iff (!i_rst_b)
    $rose(lk_oe) |-> lk_oe [*8] ##1 lk_oe [*8] ##1 !lk_oe)
    else $error("reply window is not sixteen bits");
endmodule

// File: sim/pmt_prog_model.sv
`timescale 1ns/100ps
// ==========================================================
// programmer stand-in: clock runs only inside frames, 15 ns period
module pmt_prog_model (
  // link pins
  output logic        o_clk,
  output logic        o_dat,
  output logic        o_oe,
  input  wire logic   i_line,
  input  wire logic   i_dev_oe
);
  logic [15:0] reply;  // bits shifted back by the device
  initial begin
    o_clk = 1'b0;
    o_dat = 1'b0;
    o_oe  = 1'b0;
    reply = 16'h0000;
  end
  // one frame, msb first; bits change while the clock is low
  task automatic frame(input logic [31:0] w, input logic rep);
    for (int i = 31; i >= 0; i--) begin
      o_dat = w[i];
      o_oe  = !(rep && i <= 28 && i >= 12);
      #7.5;
      // sample just ahead of the edge, the bit has stood a full period
      if (i_dev_oe) reply = {reply[14:0], i_line};
      o_clk = 1'b1;
      #7.5 o_clk = 1'b0;
    end
    o_oe = 1'b0;
    #200;  // idle gap, longer than the 150 ns the device needs
  endtask
endmodule

// File: sim/test_pmt_program_memory_table_read.sv
`timescale 1ns/100ps
// ==========================================================
// bench: link writes and reads, all table read forms, latch access
module test_pmt_program_memory_table_read;
  logic i_clk, i_rst_b, i_tab_req, i_tblp_wr, i_ptr_high_wr, i_latch_wr;
  logic [22:0] eseen;  // eeprom write as caught by the watcher
  logic [7:0] eerd;    // eeprom word offered to the device
  logic [1:0] i_tab_kind;
  logic [9:0] i_tab_dest, dm_addr;
  logic [7:0] i_ptr_wdata, tpl, tbl, dm_data, ee_wdata;
  logic pclk, pdat, poe, ddat, doe, line, dm_wr, ivalid, busy, ee_wr;
  logic [3:0] tph;
  logic [11:0] fetch;
  logic [15:0] instr;
  logic [13:0] ee_addr;
  int errors, comparisons;
  pmt_program_memory_table_read #(.PW(12)) u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_prog_serial_clock(pclk), .i_tab_req(i_tab_req), .i_tab_kind(i_tab_kind),
    .i_tab_dest(i_tab_dest), .i_ptr_wdata(i_ptr_wdata), .i_tblp_wr(i_tblp_wr),
    .i_ptr_high_wr(i_ptr_high_wr), .i_latch_wr(i_latch_wr), .o_table_pointer_low(tpl),
    .o_table_pointer_high(tph), .o_table_high_byte_latch(tbl), .o_dm_wr(dm_wr),
    .o_dm_addr(dm_addr), .o_dm_data(dm_data), .o_fetch_addr(fetch), .o_instr(instr),
    .o_instr_valid(ivalid), .o_busy(busy), .o_ee_wr(ee_wr), .o_ee_addr(ee_addr),
    .o_ee_wdata(ee_wdata), .i_ee_rdata(eerd), .i_prog_serial_data(line),
    .o_prog_serial_data(ddat), .o_prog_serial_data_oe(doe));
  pmt_prog_model u_prg (.o_clk(pclk), .o_dat(pdat), .o_oe(poe), .i_line(line),
    .i_dev_oe(doe));
  // released line shows the inverse of its last level
  always @(doe or ddat or poe or pdat) line = doe ? ddat : (poe ? pdat : ~line);
  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input int s, input logic [7:0] v);
    @(posedge i_clk);
    i_ptr_wdata <= v;
    {i_tblp_wr, i_ptr_high_wr, i_latch_wr} <= {s == 0, s == 1, s == 2};
    @(posedge i_clk);
    {i_tblp_wr, i_ptr_high_wr, i_latch_wr} <= 3'h0;
  endtask
  // table read: word shows one edge after the taking edge, low byte one edge later
  // requests come from one caller only and never overlap
  task automatic tab(input logic [1:0] k, input logic [9:0] d, input logic [15:0] w);
    #1;
    for (int n = 0; n < 20 && busy !== 1'b0; n++) begin
      @(posedge i_clk);
      #1;
    end
    @(posedge i_clk);
    i_tab_req <= 1'b1;
    i_tab_kind <= k;
    i_tab_dest <= d;
    @(posedge i_clk);
    i_tab_req <= 1'b0;
    @(posedge i_clk);
    #1 chk({busy, ivalid, instr}, {2'b10, w});
    @(posedge i_clk);
    #1 chk({busy, dm_wr}, 2'b01);
    chk(dm_addr, k[1] ? d : {2'h0, d[7:0]});
    chk(dm_data, w[7:0]);
    chk(tbl, w[15:8] & 8'h0f);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    #100000 errors++;
    summarize();
  end
  initial begin
    {i_rst_b, i_tab_req, i_tblp_wr, i_ptr_high_wr, i_latch_wr} = 5'h00;
    {i_tab_kind, i_tab_dest, i_ptr_wdata} = 20'h00000;
    eerd = 8'h5e;
    repeat (2) @(posedge i_clk);
    i_rst_b <= 1'b1;
    @(posedge i_clk);
    #1 chk(fetch, 12'h000);
    chk({ivalid, busy}, 2'b10);
    chk({tpl, tph, tbl},
        {pmt_pkg::TBLP_RST, pmt_pkg::PTR_HIGH_RST[3:0], pmt_pkg::LATCH_RST});
    u_prg.frame({2'b10, 14'hf06, 16'habcd}, 1'b0);
    u_prg.frame({2'b10, 14'h345, 16'h0234}, 1'b0);
    // the write pulse stands one cycle, so the watcher keeps what it saw
    fork
      u_prg.frame({2'b11, 14'h0021, 16'h005e}, 1'b0);
      begin
        for (int n = 0; n < 200 && ee_wr !== 1'b1; n++) #10;
        eseen = {ee_wr, ee_addr, ee_wdata};
      end
    join
    chk(eseen, {1'b1, 14'h0021, 8'h5e});
    u_prg.frame({2'b00, 14'h345, 16'h0000}, 1'b0);
    u_prg.frame(32'h00000000, 1'b1);
    chk(u_prg.reply, 16'h0234);
    u_prg.frame({2'b01, 14'h0021, 16'h0000}, 1'b0);
    u_prg.frame(32'h00000000, 1'b1);
    chk(u_prg.reply, {8'h00, eerd});
    wreg(0, 8'h45);
    wreg(1, 8'h03);
    #1 chk({tpl, tph}, {8'h45, 4'h3});
    tab(pmt_pkg::near_table_read_current_page, 10'h2a5, 16'h0234);
    tab(pmt_pkg::far_table_read_current_page, 10'h2a5, 16'h0234);
    wreg(0, 8'h06);
    tab(pmt_pkg::near_table_read_last_page, 10'h180, 16'habcd);
    tab(pmt_pkg::far_table_read_last_page, 10'h180, 16'habcd);
    wreg(2, 8'h5a);
    #1 chk(tbl, 8'h5a);
    summarize();
  end
endmodule
